// *** dim_pkg.sv ***
package dim_pkg;
   // register offsets
   localparam logic [7:0] OFF_BRIGHTNESS = 8'h00;
   localparam logic [7:0] OFF_CONTROL = 8'h01;
   localparam logic [7:0] OFF_STATUS = 8'h02;
   localparam logic [7:0] OFF_IDENT = 8'h03;

   // reset values and unmapped read value
   localparam logic [7:0] BRIGHTNESS_RESET = 8'hff;
   localparam logic [2:0] CONTROL_RESET = 3'h0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] FACTOR_FULL = 8'hff;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // control field positions
   localparam int CTL_ON_BIT = 0;
   localparam int CTL_SRC_BIT = 1;
   localparam int CTL_INTERP_BIT = 2;

   // status field positions
   localparam int ST_FAULT_BIT = 0;
   localparam int ST_THERMAL_BIT = 1;
   localparam int ST_OVERCUR_BIT = 2;
   localparam int ST_BL_ON_BIT = 3;
   localparam int ST_ONE_CH_BIT = 4;
   localparam int ST_MULTI_CH_BIT = 5;

   // identification layout
   localparam logic ID_PANEL_BIT = 1'b1;
   localparam logic [3:0] MAKER_CODE_DEF = 4'ha; // arbitrary value
   localparam logic [2:0] REVISION_DEF = 3'h1; // arbitrary value

   // bus addressing, turn-on timing, channel count and product divisor
   localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2c;
   localparam int CLK_MHZ = 200;
   localparam int ON_DELAY_MS = 10;
   localparam int ON_DELAY_CYC = ON_DELAY_MS * 1000 * CLK_MHZ;
   localparam int CHANNELS = 8;
   localparam int DIV_BY_FULL = 255;
endpackage

// *** pin_sync_if.sv ***
`timescale 1ns/100ps
interface pin_sync_if #(
   parameter int W = 2
);
   logic [W-1:0] raw;
   logic [W-1:0] clean;

   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// *** pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 2,
   parameter logic [W-1:0] RESET_VAL = '1
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   pin_sync_if.sync port
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] clean_q;

   // three stage chain, first stage feeds only the second
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end else begin
         s1_q <= port.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a bit changes once stages two and three agree
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         clean_q <= RESET_VAL;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               clean_q[i] <= s2_q[i];
            end
         end
      end
   end

   assign port.clean = clean_q;
endmodule

// *** backlight_dimming_register_bank.sv ***
// Operation
// - brightness register at 0x00, read/write, resets to 0xff.
// - completed write byte in bus or product mode sets the new brightness.
// - code 0xff is full output, 0x00 is 0.4 percent, 256 steps.
// - writes to brightness are dropped while the pin source is selected.
// - reading brightness returns the stored level in every mode.
// - control register at 0x01, bits 0 to 2 read/write, resets to 0x00.
// - control bits 3 to 7 read zero and ignore writes.
// - writing 1 to on bit 0 lights the outputs within 10 ms.
// - writing 0 to on bit 0 turns the outputs off at once.
// - bit 1 selects pin or bus code; bit 2 applies only with bit 1 clear.
// - in pin mode the duty comes only from the measured pin duty.
// - interpretation 1 with source 0 ignores the pin, uses bus code.
// - both mode bits 0 give normalized product of code and pin duty.
// - on entering product mode the pin factor is full until measured.
// - read-only status at 0x02, resets to 0x00, bits 6 and 7 zero.
// - status bit 5 for two or more channels down, bit 4 for one.
// - status bit 3 shows backlight on or off.
// - status bit 2 overcurrent, bit 1 thermal shutdown, else zero.
// - status bit 0 is the OR of all fault bits.
// - identification at 0x03: bit 7 one, maker code, revision.
// - after power-up backlight stays off until the host turns it on.
// - channels disabled after startup set the shutdown status bits.
`timescale 1ns/100ps
module backlight_dimming_register_bank #(
   parameter int unsigned ON_DELAY_CYCLES = dim_pkg::ON_DELAY_CYC,
   parameter logic [6:0] SLAVE_ADDR = dim_pkg::SLAVE_ADDR_DEF,
   parameter logic [3:0] MAKER_CODE = dim_pkg::MAKER_CODE_DEF,
   parameter logic [2:0] REVISION = dim_pkg::REVISION_DEF
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [7:0] duty_measured_i,
   input wire logic duty_valid_i,
   input wire logic [dim_pkg::CHANNELS-1:0] channel_shutdown_i,
   input wire logic input_overcurrent_flag_i,
   input wire logic thermal_shutdown_flag_i,
   output logic led_enable_o,
   output logic [8:0] dim_duty_o,
   output logic [1:0] dim_mode_o
);
   import dim_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_ADDR = 4'b0001,
      S_ADDR_ACK = 4'b0010,
      S_CMD = 4'b0011,
      S_CMD_ACK = 4'b0100,
      S_WDATA = 4'b0101,
      S_WDATA_ACK = 4'b0110,
      S_RDATA = 4'b0111,
      S_RACK = 4'b1000
   } bus_state_e;
   typedef enum logic [1:0] {
      M_PRODUCT = 2'b00,
      M_BUS = 2'b01,
      M_PIN = 2'b10
   } dim_mode_e;

   pin_sync_if #(.W(2)) pins ();
   logic scl, sda, scl_prev_q, sda_prev_q;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   bus_state_e state_q;
   logic [3:0] bit_cnt_q, down_cnt;
   logic [7:0] shift_q, cmd_q, wdata_q, rd_data, bright_q;
   logic rw_q, nak_q, drive_low_q, wr_q;
   logic [2:0] ctrl_q;
   logic [7:0] status_q, status_d, factor_q, eff_code;
   logic [31:0] on_cnt_q;
   logic on_pending_q, led_on_q, product_prev_q;
   dim_mode_e mode;
   logic [15:0] product_full;
   logic [8:0] duty_q;
   // bus pins cross into the core clock domain
   assign pins.raw = {scl_i, sda_i};
   pin_sync #(.W(2), .RESET_VAL(2'b11)) u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .port(pins.sync)
   );
   assign scl = pins.clean[1];
   assign sda = pins.clean[0];
   // previous line levels for edge detection
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl;
         sda_prev_q <= sda;
      end
   end
   // line events
   assign scl_rise = scl & ~scl_prev_q;
   assign scl_fall = ~scl & scl_prev_q;
   assign start_cond = scl & scl_prev_q & sda_prev_q & ~sda;
   assign stop_cond = scl & scl_prev_q & ~sda_prev_q & sda;
   // register read mux by command code
   always_comb begin
      case (cmd_q)
         OFF_BRIGHTNESS: rd_data = bright_q;
         OFF_CONTROL: rd_data = {5'h00, ctrl_q};
         OFF_STATUS: rd_data = status_q;
         OFF_IDENT: rd_data = {ID_PANEL_BIT, MAKER_CODE, REVISION};
         default: rd_data = READ_UNMAPPED;
      endcase
   end
   // bus slave: address, command, write byte and read byte
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state_q <= S_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         cmd_q <= 8'h00;
         rw_q <= 1'b0;
         nak_q <= 1'b0;
         drive_low_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         wr_q <= 1'b0;
         if (start_cond) begin
            state_q <= S_ADDR;
            bit_cnt_q <= 4'h0;
            drive_low_q <= 1'b0;
         end else if (stop_cond) begin
            state_q <= S_IDLE;
            drive_low_q <= 1'b0;
         end else begin
            case (state_q)
               S_ADDR, S_CMD, S_WDATA: begin
                  if (scl_rise && bit_cnt_q < 4'h8) begin
                     shift_q <= {shift_q[6:0], sda};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == 4'h8) begin
                     bit_cnt_q <= 4'h0;
                     if (state_q == S_ADDR) begin
                        if (shift_q[7:1] == SLAVE_ADDR) begin
                           rw_q <= shift_q[0];
                           drive_low_q <= 1'b1;
                           state_q <= S_ADDR_ACK;
                        end else begin
                           state_q <= S_IDLE;
                        end
                     end else if (state_q == S_CMD) begin
                        cmd_q <= shift_q;
                        drive_low_q <= 1'b1;
                        state_q <= S_CMD_ACK;
                     end else begin
                        wdata_q <= shift_q;
                        wr_q <= 1'b1;
                        drive_low_q <= 1'b1;
                        state_q <= S_WDATA_ACK;
                     end
                  end
               end
               S_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (rw_q) begin
                        drive_low_q <= ~rd_data[7];
                        shift_q <= {rd_data[6:0], 1'b0};
                        bit_cnt_q <= 4'h1;
                        state_q <= S_RDATA;
                     end else begin
                        drive_low_q <= 1'b0;
                        state_q <= S_CMD;
                     end
                  end
               end
               S_CMD_ACK, S_WDATA_ACK: begin
                  if (scl_fall) begin
                     drive_low_q <= 1'b0;
                     state_q <= S_WDATA;
                  end
               end
               S_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_q < 4'h8) begin
                        drive_low_q <= ~shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end else begin
                        drive_low_q <= 1'b0;
                        nak_q <= 1'b0;
                        state_q <= S_RACK;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     nak_q <= sda;
                  end else if (scl_fall) begin
                     if (nak_q) begin
                        state_q <= S_IDLE;
                     end else begin
                        drive_low_q <= ~rd_data[7];
                        shift_q <= {rd_data[6:0], 1'b0};
                        bit_cnt_q <= 4'h1;
                        state_q <= S_RDATA;
                     end
                  end
               end
               default: begin
                  state_q <= S_IDLE;
                  drive_low_q <= 1'b0;
               end
            endcase
         end
      end
   end
   // open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = drive_low_q;
   // brightness code register
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         bright_q <= BRIGHTNESS_RESET;
      end else if (wr_q && cmd_q == OFF_BRIGHTNESS &&
                   !ctrl_q[CTL_SRC_BIT]) begin
         bright_q <= wdata_q;
      end
   end
   // control register, reserved bits dropped
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ctrl_q <= CONTROL_RESET;
      end else if (wr_q && cmd_q == OFF_CONTROL) begin
         ctrl_q <= wdata_q[2:0];
      end
   end
   // turn-on delay after on bit written
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         on_cnt_q <= 32'h0;
         on_pending_q <= 1'b0;
         led_on_q <= 1'b0;
      end else if (!ctrl_q[CTL_ON_BIT]) begin
         on_cnt_q <= 32'h0;
         on_pending_q <= 1'b0;
         led_on_q <= 1'b0;
      end else if (!led_on_q && !on_pending_q) begin
         on_cnt_q <= 32'h0;
         on_pending_q <= 1'b1;
      end else if (on_pending_q) begin
         if (on_cnt_q >= ON_DELAY_CYCLES - 1) begin
            on_pending_q <= 1'b0;
            led_on_q <= 1'b1;
         end else begin
            on_cnt_q <= on_cnt_q + 32'h1;
         end
      end
   end
   // off takes effect the cycle the bit clears
   assign led_enable_o = led_on_q & ctrl_q[CTL_ON_BIT];
   // dimming source selection
   always_comb begin
      if (ctrl_q[CTL_SRC_BIT]) begin
         mode = M_PIN;
      end else if (ctrl_q[CTL_INTERP_BIT]) begin
         mode = M_BUS;
      end else begin
         mode = M_PRODUCT;
      end
   end
   // pin duty factor, full scale on product mode entry
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         product_prev_q <= 1'b0;
         factor_q <= FACTOR_FULL;
      end else begin
         product_prev_q <= (mode == M_PRODUCT);
         if (duty_valid_i) begin
            factor_q <= duty_measured_i;
         end else if (mode == M_PRODUCT && !product_prev_q) begin
            factor_q <= FACTOR_FULL;
         end
      end
   end
   // normalized product, rounded down
   assign product_full = (16'(bright_q) * 16'(factor_q)) /
                         16'(DIV_BY_FULL);
   always_comb begin
      case (mode)
         M_PIN: eff_code = factor_q;
         M_BUS: eff_code = bright_q;
         M_PRODUCT: eff_code = product_full[7:0];
         default: eff_code = bright_q;
      endcase
   end
   // duty in 256ths: code 0 is one step, code 255 is all
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         duty_q <= {1'b0, BRIGHTNESS_RESET} + 9'h001;
      end else begin
         duty_q <= {1'b0, eff_code} + 9'h001;
      end
   end
   assign dim_duty_o = duty_q;
   assign dim_mode_o = mode;
   // count disabled channels
   always_comb begin
      down_cnt = 4'h0;
      for (int i = 0; i < CHANNELS; i++) begin
         down_cnt = down_cnt + {3'h0, channel_shutdown_i[i]};
      end
   end
   // status word from live conditions
   always_comb begin
      status_d = STATUS_RESET;
      status_d[ST_MULTI_CH_BIT] = (down_cnt >= 4'h2);
      status_d[ST_ONE_CH_BIT] = (down_cnt == 4'h1);
      status_d[ST_BL_ON_BIT] = led_enable_o;
      status_d[ST_OVERCUR_BIT] = input_overcurrent_flag_i;
      status_d[ST_THERMAL_BIT] = thermal_shutdown_flag_i;
      status_d[ST_FAULT_BIT] = status_d[ST_MULTI_CH_BIT] |
                               status_d[ST_ONE_CH_BIT] |
                               status_d[ST_OVERCUR_BIT] |
                               status_d[ST_THERMAL_BIT];
   end
   // status register sampled every cycle
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end
endmodule

// *** bdrb_sva.sv ***
`timescale 1ns/100ps
module bdrb_sva (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [7:0] duty_measured_i,
   input wire logic duty_valid_i,
   input wire logic led_enable_o,
   input wire logic [8:0] dim_duty_o,
   input wire logic [1:0] dim_mode_o
);
   // one clock domain for every check
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_reset_quiet;
      disable iff (1'b0)
      !reset_n_i |=> !led_enable_o && !sda_oe_o && dim_duty_o == 9'h100;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not quiet after reset");
   property p_pin_hold;
      (dim_mode_o == 2'b10 && !duty_valid_i) [*3] |-> $stable(dim_duty_o);
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("pin mode duty moved without a measurement");
   property p_oe_scl_low;
      $changed(sda_oe_o) |-> !scl_i && !sda_o;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("data line moved while bus clock high");
   property p_led_fall;
      $fell(led_enable_o) |-> !scl_i;
   endproperty
   a_led_fall: assert property (p_led_fall)
      else $error("outputs dropped outside a write commit");
   property p_duty_range;
      dim_duty_o != 9'h000 && dim_duty_o <= 9'h100;
   endproperty
   a_duty_range: assert property (p_duty_range)
      else $error("duty outside 1 to 256");
   property p_pin_track;
      (dim_mode_o == 2'b10 && duty_valid_i)
      ##1 (dim_mode_o == 2'b10 && !duty_valid_i) [*3]
      |-> dim_duty_o == {1'b0, $past(duty_measured_i, 3)} + 9'h001;
   endproperty
   a_pin_track: assert property (p_pin_track)
      else $error("pin mode duty does not follow measurement");
   property p_bus_steady;
      (dim_mode_o == 2'b01 && scl_i) [*8] |-> $stable(dim_duty_o);
   endproperty
   a_bus_steady: assert property (p_bus_steady)
      else $error("bus mode duty moved without a write");
   property p_enter_product;
      (dim_mode_o == 2'b01) [*3]
      ##1 (dim_mode_o == 2'b00 && !duty_valid_i) [*3]
      |-> dim_duty_o == $past(dim_duty_o, 3);
   endproperty
   a_enter_product: assert property (p_enter_product)
      else $error("product mode did not start at full factor");
endmodule

bind backlight_dimming_register_bank bdrb_sva u_sva (
   .ref_clk_i(ref_clk_i),
   .reset_n_i(reset_n_i),
   .scl_i(scl_i),
   .sda_o(sda_o),
   .sda_oe_o(sda_oe_o),
   .duty_measured_i(duty_measured_i),
   .duty_valid_i(duty_valid_i),
   .led_enable_o(led_enable_o),
   .dim_duty_o(dim_duty_o),
   .dim_mode_o(dim_mode_o)
);

// *** smbus_host.sv ***
`timescale 1ns/100ps
module smbus_host (
   input wire logic ref_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // bus idles with clock high and data released
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // one bit: data moves mid-low, sampled mid-high, clock low 16 clk
   task automatic bit_x(input logic b, output logic r);
      sda_low_o <= !b;
      w(8);
      scl_o <= 1'b1;
      w(8);
      r = sda_i;
      w(8);
      scl_o <= 1'b0;
      w(8);
   endtask
   // start or repeated start
   task automatic start_c;
      sda_low_o <= 1'b0;
      w(8);
      scl_o <= 1'b1;
      w(8);
      sda_low_o <= 1'b1;
      w(8);
      scl_o <= 1'b0;
      w(8);
   endtask
   task automatic stop_c;
      sda_low_o <= 1'b1;
      w(8);
      scl_o <= 1'b1;
      w(8);
      sda_low_o <= 1'b0;
      w(16);
   endtask
   // byte out msb first, acknowledge slot left released
   task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(1'b1, r);
      ack = !r;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] c,
                     input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k1, k2, k3;
      start_c();
      byte_x({a, 1'b0}, q, k1);
      byte_x(c, q, k2);
      byte_x(d, q, k3);
      stop_c();
      ok = k1 & k2 & k3;
   endtask
   // read ends with no acknowledge from the host
   task automatic rd(input logic [6:0] a, input logic [7:0] c,
                     output logic [7:0] v);
      logic [7:0] q;
      logic k;
      start_c();
      byte_x({a, 1'b0}, q, k);
      byte_x(c, q, k);
      start_c();
      byte_x({a, 1'b1}, q, k);
      byte_x(8'hff, v, k);
      stop_c();
   endtask
endmodule

// *** backlight_dimming_register_bank_tb.sv ***
`timescale 1ns/100ps
module backlight_dimming_register_bank_tb;
   import dim_pkg::*;
   typedef struct packed {
      logic [7:0] ch;
      logic [1:0] f;
      logic [7:0] st;
   } row_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic scl, host_low, sda_oe, sda_o, led, ok;
   logic vld = 1'b0;
   logic ovc = 1'b0;
   logic thr = 1'b0;
   logic [7:0] duty = 8'h00;
   logic [7:0] chs = 8'h00;
   logic [7:0] v;
   logic [8:0] dd;
   logic [1:0] mode;
   int miscompares = 0;
   int check_count = 0;
   // channels, {overcurrent, thermal}, expected status
   row_s rows [7] = '{'{8'h00, 2'h0, 8'h00}, '{8'h04, 2'h0, 8'h11},
      '{8'h81, 2'h0, 8'h21}, '{8'hff, 2'h0, 8'h21},
      '{8'h00, 2'h2, 8'h05}, '{8'h00, 2'h1, 8'h03},
      '{8'h10, 2'h3, 8'h17}};
   // open-drain data line with pull-up
   wire sda_w = !(host_low || sda_oe);
   always #2.5 clk = ~clk;

   smbus_host host (
      .ref_clk_i(clk),
      .sda_i(sda_w),
      .scl_o(scl),
      .sda_low_o(host_low)
   );
   backlight_dimming_register_bank #(.ON_DELAY_CYCLES(20)) dut (
      .ref_clk_i(clk),
      .reset_n_i(rst_n),
      .scl_i(scl),
      .sda_i(sda_w),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe),
      .duty_measured_i(duty),
      .duty_valid_i(vld),
      .channel_shutdown_i(chs),
      .input_overcurrent_flag_i(ovc),
      .thermal_shutdown_flag_i(thr),
      .led_enable_o(led),
      .dim_duty_o(dd),
      .dim_mode_o(mode)
   );

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] c, input logic [7:0] exp);
      host.rd(SLAVE_ADDR_DEF, c, v);
      chk({1'b0, v}, {1'b0, exp});
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      host.wr(SLAVE_ADDR_DEF, c, d, ok);
   endtask
   // one fresh measurement, then settle
   task automatic pulse(input logic [7:0] d);
      @(posedge clk);
      duty <= d;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task end_of_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // watchdog well above the expected run length
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      end_of_test();
   end

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(dd, 9'h100);
      chk({8'h00, led}, 9'h000);
      rchk(OFF_BRIGHTNESS, BRIGHTNESS_RESET);
      rchk(OFF_CONTROL, 8'h00);
      rchk(OFF_IDENT, {ID_PANEL_BIT, MAKER_CODE_DEF, REVISION_DEF});
      rchk(8'h04, READ_UNMAPPED);
      foreach (rows[i]) begin
         @(posedge clk);
         chs <= rows[i].ch;
         {ovc, thr} <= rows[i].f;
         rchk(OFF_STATUS, rows[i].st);
      end
      chs <= 8'h00;
      {ovc, thr} <= 2'h0;
      $display("test reset and status done");
      wr(OFF_CONTROL, 8'hfd);
      chk({8'h00, led}, 9'h001);
      rchk(OFF_CONTROL, 8'h05);
      rchk(OFF_STATUS, 8'h08);
      chk({7'h00, mode}, 9'h001);
      wr(OFF_BRIGHTNESS, 8'h00);
      pulse(8'h33);
      chk(dd, 9'h001);
      rchk(OFF_BRIGHTNESS, 8'h00);
      wr(OFF_BRIGHTNESS, 8'h80);
      $display("test bus mode done");
      wr(OFF_CONTROL, 8'h03);
      chk({7'h00, mode}, 9'h002);
      pulse(8'h40);
      chk(dd, 9'h041);
      wr(OFF_BRIGHTNESS, 8'h55);
      rchk(OFF_BRIGHTNESS, 8'h80);
      $display("test pin mode done");
      wr(OFF_CONTROL, 8'h05);
      wr(OFF_CONTROL, 8'h01);
      chk(dd, 9'h081);
      pulse(8'h40);
      chk(dd, 9'h021);
      $display("test product mode done");
      wr(OFF_CONTROL, 8'h00);
      chk({8'h00, led}, 9'h000);
      wr(OFF_STATUS, 8'hff);
      rchk(OFF_STATUS, 8'h00);
      host.wr(SLAVE_ADDR_DEF ^ 7'h01, OFF_BRIGHTNESS, 8'h11, ok);
      chk({8'h00, ok}, 9'h000);
      rchk(OFF_BRIGHTNESS, 8'h80);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(OFF_BRIGHTNESS, BRIGHTNESS_RESET);
      $display("test off and second reset done");
      end_of_test();
   end
endmodule
